// ===== pwt_regs.svh
// register map and field constants of the eight-channel waveform timer
// assumes a 32-bit AXI4-Lite slave, word aligned offsets
`ifndef PWT_REGS_SVH
`define PWT_REGS_SVH
`define PWT_OFF_ENABLE   8'h00
`define PWT_OFF_POLARITY 8'h04
`define PWT_OFF_CENTRE   8'h08
`define PWT_OFF_PCM      8'h0C
`define PWT_OFF_JOIN     8'h10
`define PWT_OFF_STATUS   8'h14
`define PWT_OFF_PERIOD0  8'h20
`define PWT_OFF_DUTY0    8'h40
`define PWT_OFF_COUNT0   8'h60
`define PWT_BANK_SPAN    8'h20
`define PWT_IDX_LSB      2
`define PWT_IDX_MSB      4
`define PWT_JOIN_W       4
`define PWT_RESP_OKAY    2'h0
`define PWT_RESP_SLVERR  2'h2
`define PWT_RST_PERIOD   8'hFF
`define PWT_RST_DUTY     8'h00
`endif

// ===== pwt_pkg.sv
// types shared by the waveform timer and its channel slice
// assumes pwt_regs.svh for numeric constants
package pwt_pkg;
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty;
    logic        centre;
    logic        pcm;
    logic        enable;
    logic        wide;
  } pwt_cfg_s;
  typedef enum logic {PWT_UP, PWT_DOWN} pwt_dir_e;
endpackage

// ===== pwt_chan.sv
// one counting slice: 8-bit, or 16-bit when a pair is joined
// assumes configuration stable from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module pwt_chan
  import pwt_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  input  wire pwt_cfg_s i_cfg,
  output logic          o_wave,
  output logic [15:0]   o_count
);
  logic [15:0] cnt_ff;
  logic [15:0] acc_ff;
  logic        wave_ff;
  pwt_dir_e    dir_ff;
  logic [15:0] per;
  logic [15:0] duty;
  logic [16:0] nxt_acc;

  assign per  = i_cfg.wide ? i_cfg.period : {8'h00, i_cfg.period[7:0]};
  assign duty = i_cfg.wide ? i_cfg.duty : {8'h00, i_cfg.duty[7:0]};
  assign o_count = cnt_ff;
  assign o_wave  = wave_ff;
  // pcm: first-order delta-sigma, spreads the pulses over the period
  assign nxt_acc = {1'b0, acc_ff} + {1'b0, duty};

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_cfg.enable) begin
      cnt_ff <= 16'h0000;
      dir_ff <= PWT_UP;
    end else if (i_cfg.centre && !i_cfg.pcm) begin
      if (dir_ff == PWT_UP) begin
        if (cnt_ff >= per) begin
          dir_ff <= PWT_DOWN;
          cnt_ff <= (per == 16'h0000) ? 16'h0000 : cnt_ff - 16'h0001;
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end else if (cnt_ff == 16'h0000) begin
        dir_ff <= PWT_UP;
        cnt_ff <= (per == 16'h0000) ? 16'h0000 : 16'h0001;
      end else begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end else begin
      cnt_ff <= (cnt_ff >= per) ? 16'h0000 : cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_cfg.enable || !i_cfg.pcm) begin
      acc_ff <= 16'h0000;
    end else if (nxt_acc[15:0] > per || nxt_acc[16]) begin
      acc_ff <= nxt_acc[15:0] - per - 16'h0001;
    end else begin
      acc_ff <= nxt_acc[15:0];
    end
  end

  // raw active level; polarity is applied at the top
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_cfg.enable) begin
      wave_ff <= 1'b0;
    end else if (i_cfg.pcm) begin
      wave_ff <= (nxt_acc[15:0] > per) || nxt_acc[16];
    end else if (i_cfg.centre) begin
      // duty above period stays active, zero never; symmetric about count zero
      wave_ff <= (duty > per) || (cnt_ff < duty);
    end else begin
      wave_ff <= (duty > per) || (cnt_ff < duty);
    end
  end
endmodule
`default_nettype wire

// ===== pwt_top.sv
// eight-channel waveform timer with AXI4-Lite register slave
// assumes one 10 MHz clock, synchronous active high reset
`timescale 1ns/1ns
`default_nettype none
`include "pwt_regs.svh"
// Overview of operation
// - eight 8-bit channels, each own counter
// - each channel programmable period and duty
// - waveforms run continuously without software
// - duty spans never active to always active
// - pulse-code modulation mode per channel
// - per-channel software output polarity
// - left- or centre-aligned selectable per channel
// - adjacent pairs join into 16-bit channels
// - mixes 8/0 6/1 4/2 2/3 0/4 allowed
module pwt_top
  import pwt_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [7:0]       O_PWM
);
  // slice wiring and register map are fixed at eight channels
  if (NUM_CH != 8) begin : g_bad_ch
    $error("pwt_top supports exactly eight channels");
  end

  logic [7:0]  enable_ff;
  logic [7:0]  polarity_ff;
  logic [7:0]  centre_ff;
  logic [7:0]  pcm_ff;
  logic [3:0]  join_ff;
  logic [7:0]  period_ff [8];
  logic [7:0]  duty_ff   [8];
  logic [7:0]  pwm_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic [7:0]  raw_wave;
  logic [15:0] count [8];
  pwt_cfg_s    cfg [8];
  logic        wr_go;
  logic [31:0] nxt_rdata;
  logic        nxt_rerr;
  logic        nxt_werr;

  // strobed byte-lane merge, used for every register write except join, which tests wstrb_ff[0] itself
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a[1:0] == 2'h0) &&
             (a <= `PWT_OFF_STATUS ||
              (a >= `PWT_OFF_PERIOD0 && a < `PWT_OFF_PERIOD0 + `PWT_BANK_SPAN) ||
              (a >= `PWT_OFF_DUTY0   && a < `PWT_OFF_DUTY0   + `PWT_BANK_SPAN) ||
              (a >= `PWT_OFF_COUNT0  && a < `PWT_OFF_COUNT0  + `PWT_BANK_SPAN));
  endfunction

  // channel configuration; joined pair uses odd channel as high byte
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ch
      localparam int EV = g & 6;
      always_comb begin
        cfg[g].wide   = join_ff[g/2];
        cfg[g].period = join_ff[g/2] ? {period_ff[EV+1], period_ff[EV]} : {8'h00, period_ff[g]};
        cfg[g].duty   = join_ff[g/2] ? {duty_ff[EV+1], duty_ff[EV]} : {8'h00, duty_ff[g]};
        cfg[g].centre = centre_ff[join_ff[g/2] ? EV + 1 : g];
        cfg[g].pcm    = pcm_ff[join_ff[g/2] ? EV + 1 : g];
        // a joined pair runs only its odd slice; even slice idles
        cfg[g].enable = join_ff[g/2] ? ((g % 2 == 1) && enable_ff[EV+1]) : enable_ff[g];
      end
      pwt_chan u_chan (
        .i_clk   (I_SYS_CLK),
        .i_rst   (I_SYS_RST),
        .i_cfg   (cfg[g]),
        .o_wave  (raw_wave[g]),
        .o_count (count[g])
      );
    end
  endgenerate

  // joined pair drives the odd output; even output follows the same wave
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      pwm_ff <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        pwm_ff[i] <= (join_ff[i/2] ? raw_wave[i | 1] : raw_wave[i]) ^ polarity_ff[i];
      end
    end
  end

  // write address and data taken in either order, one write at a time
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (I_AWVALID && awready_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= I_AWADDR;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (I_WVALID && wready_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= I_WDATA;
        wstrb_ff  <= I_WSTRB;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  assign wr_go    = aw_held_ff && w_held_ff && !bvalid_ff;
  assign nxt_werr = !map_ok(awaddr_ff) || awaddr_ff == `PWT_OFF_STATUS || awaddr_ff >= `PWT_OFF_COUNT0;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `PWT_RESP_OKAY;
    end else begin
      awready_ff <= !aw_held_ff && !(I_AWVALID && awready_ff) && !bvalid_ff;
      wready_ff  <= !w_held_ff && !(I_WVALID && wready_ff) && !bvalid_ff;
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= nxt_werr ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY;
      end else if (I_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // register file; written values steer every slice directly
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      enable_ff   <= 8'h00;
      polarity_ff <= 8'h00;
      centre_ff   <= 8'h00;
      pcm_ff      <= 8'h00;
      join_ff     <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        period_ff[i] <= `PWT_RST_PERIOD;
        duty_ff[i]   <= `PWT_RST_DUTY;
      end
    end else if (wr_go && !nxt_werr) begin
      case (awaddr_ff)
        `PWT_OFF_ENABLE:   enable_ff   <= lane0(enable_ff, wdata_ff, wstrb_ff);
        `PWT_OFF_POLARITY: polarity_ff <= lane0(polarity_ff, wdata_ff, wstrb_ff);
        `PWT_OFF_CENTRE:   centre_ff   <= lane0(centre_ff, wdata_ff, wstrb_ff);
        `PWT_OFF_PCM:      pcm_ff      <= lane0(pcm_ff, wdata_ff, wstrb_ff);
        `PWT_OFF_JOIN:     join_ff     <= wstrb_ff[0] ? wdata_ff[`PWT_JOIN_W-1:0] : join_ff;
        default: begin
          if (awaddr_ff < `PWT_OFF_DUTY0) begin
            period_ff[awaddr_ff[`PWT_IDX_MSB:`PWT_IDX_LSB]] <=
              lane0(period_ff[awaddr_ff[`PWT_IDX_MSB:`PWT_IDX_LSB]], wdata_ff, wstrb_ff);
          end else begin
            duty_ff[awaddr_ff[`PWT_IDX_MSB:`PWT_IDX_LSB]] <=
              lane0(duty_ff[awaddr_ff[`PWT_IDX_MSB:`PWT_IDX_LSB]], wdata_ff, wstrb_ff);
          end
        end
      endcase
    end
  end

  always_comb begin
    nxt_rerr  = !map_ok(I_ARADDR);
    nxt_rdata = 32'h0000_0000;
    case (I_ARADDR)
      `PWT_OFF_ENABLE:   nxt_rdata = {24'h000000, enable_ff};
      `PWT_OFF_POLARITY: nxt_rdata = {24'h000000, polarity_ff};
      `PWT_OFF_CENTRE:   nxt_rdata = {24'h000000, centre_ff};
      `PWT_OFF_PCM:      nxt_rdata = {24'h000000, pcm_ff};
      `PWT_OFF_JOIN:     nxt_rdata = {28'h0000000, join_ff};
      `PWT_OFF_STATUS:   nxt_rdata = {24'h000000, pwm_ff};
      default: begin
        if (!nxt_rerr && I_ARADDR >= `PWT_OFF_COUNT0) begin
          nxt_rdata = {16'h0000, count[I_ARADDR[`PWT_IDX_MSB:`PWT_IDX_LSB]]};
        end else if (!nxt_rerr && I_ARADDR >= `PWT_OFF_DUTY0) begin
          nxt_rdata = {24'h000000, duty_ff[I_ARADDR[`PWT_IDX_MSB:`PWT_IDX_LSB]]};
        end else if (!nxt_rerr) begin
          nxt_rdata = {24'h000000, period_ff[I_ARADDR[`PWT_IDX_MSB:`PWT_IDX_LSB]]};
        end
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `PWT_RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      arready_ff <= !rvalid_ff && !(I_ARVALID && arready_ff);
      if (I_ARVALID && arready_ff) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= nxt_rerr ? `PWT_RESP_SLVERR : `PWT_RESP_OKAY;
        rdata_ff  <= nxt_rdata;
      end else if (I_RREADY) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign O_AWREADY = awready_ff;
  assign O_WREADY  = wready_ff;
  assign O_BVALID  = bvalid_ff;
  assign O_BRESP   = bresp_ff;
  assign O_ARREADY = arready_ff;
  assign O_RVALID  = rvalid_ff;
  assign O_RRESP   = rresp_ff;
  assign O_RDATA   = rdata_ff;
  assign O_PWM     = pwm_ff;
endmodule
`default_nettype wire

// ===== pwt_top_sva.sv
// bus handshake and idle output checks for the waveform timer
// assumes bound onto pwt_top, single clock domain
`timescale 1ns/1ns
`default_nettype none
module pwt_top_sva (
  input wire logic        I_SYS_CLK,
  input wire logic        I_SYS_RST,
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic [7:0]  O_PWM
);
  logic wr_seen_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) wr_seen_ff <= 1'b0;
    else if (I_AWVALID && O_AWREADY) wr_seen_ff <= 1'b1;
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
    else $error("write response late");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read response late");
  a_bresp_holds: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_rdata_holds: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  a_bresp_legal: assert property (O_BVALID |-> O_BRESP == 2'h0 || O_BRESP == 2'h2)
    else $error("illegal write response");
  a_wr_ready_idle: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write ready while pending");
  a_rd_ready_idle: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read ready while pending");
  // all channels start disabled, so nothing may move before software writes
  a_pwm_quiet: assert property (!wr_seen_ff |-> O_PWM == 8'h00)
    else $error("output active before configuration");
  c_write: cover property (O_BVALID && I_BREADY);
  c_read: cover property (O_RVALID && I_RREADY);
  c_wave: cover property ($rose(O_PWM[0]));
endmodule
bind pwt_top pwt_top_sva SVA (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_PWM(O_PWM));
`default_nettype wire

// ===== pwt_load.sv
// external load model: counts high cycles of each waveform output
// assumes outputs settle within one system clock
`timescale 1ns/1ns
`default_nettype none
module pwt_load (
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  input  wire logic [7:0]  i_pwm,
  output logic [7:0][15:0] o_hi
);
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 8; k++) begin
      o_hi[k] <= i_clr ? 16'h0000 : o_hi[k] + 16'(i_pwm[k]);
    end
  end
endmodule
`default_nettype wire

// ===== pwt_top_tb.sv
// self-checking bench: register access, refusals, waveform duty per mode
// assumes pwt_top with pwt_load measuring its outputs
`timescale 1ns/1ns
`default_nettype none
`include "pwt_regs.svh"
module pwt_top_tb;
  import pwt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clr = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pol = 8'h00;
  logic [31:0] wdata = 32'h0, lf = 32'h518EFB44;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pwm;
  logic [7:0][15:0] hi;
  int err_total = 0, compares = 0, p, w, du [8];
  always #50 clk = ~clk;
  pwt_top DUT (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_PWM(pwm));
  pwt_load LD (.i_clk(clk), .i_clr(clr), .i_pwm(pwm), .o_hi(hi));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // high cycles over whole periods; duty above period saturates to always active
  function automatic logic [31:0] exph(input int d, input int pp, input int ww, input logic inv);
    int h = ((d < pp + 1) ? d : pp + 1) * (ww / (pp + 1));
    return 32'(inv ? ww - h : h);
  endfunction
  // centre: period 2*pp, active while count below duty on both slopes
  function automatic logic [31:0] expc(input int d, input int pp, input int ww, input logic inv);
    int h = ((d == 0) ? 0 : (d > pp) ? 2 * pp : 2 * d - 1) * (ww / (2 * pp));
    return 32'(inv ? ww - h : h);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge clk);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    chk(32'(rresp), 32'(er));
    if (er == 2'h0) chk(rdata, e);
    rready <= 1'b0;
  endtask
  // settle past any leftover count, then measure whole periods
  task automatic meas(input int ww);
    repeat (700) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (ww) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic cfg(input logic [7:0] ctr, input logic [7:0] pcm);
    for (int n = 0; n < 8; n++) begin
      wr(`PWT_OFF_PERIOD0 + 8'(4 * n), 32'(p), 2'h0);
      wr(`PWT_OFF_DUTY0 + 8'(4 * n), 32'(du[n]), 2'h0);
    end
    wr(`PWT_OFF_CENTRE, 32'(ctr), 2'h0);
    wr(`PWT_OFF_PCM, 32'(pcm), 2'h0);
    wr(`PWT_OFF_POLARITY, 32'(pol), 2'h0);
    wr(`PWT_OFF_ENABLE, 32'hFF, 2'h0);
    w = (ctr != 8'h00) ? 4 * p : 4 * (p + 1);
    meas(w);
  endtask
  task automatic wrap_up;
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      rd(`PWT_OFF_PERIOD0 + 8'(4 * n), 32'hFF, 2'h0);
      rd(`PWT_OFF_DUTY0 + 8'(4 * n), 32'h00, 2'h0);
    end
    rd(`PWT_OFF_ENABLE, 32'h00, 2'h0);
    rd(`PWT_OFF_COUNT0, 32'h00, 2'h0);
    rd(`PWT_OFF_STATUS, 32'h00, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(`PWT_OFF_STATUS, 32'h1, 2'h2);
    wr(`PWT_OFF_COUNT0, 32'h1, 2'h2);
    wr(8'h02, 32'h1, 2'h2);
    for (int r = 0; r < 4; r++) begin
      lf = nx(lf);
      p = 8 + int'(lf % 24);
      pol = lf[15:8];
      for (int n = 0; n < 8; n++) begin
        lf = nx(lf);
        du[n] = (n == 0) ? 0 : (n == 1) ? p + 1 : int'(lf % (p + 3));
      end
      cfg(8'h00, 8'h00);
      for (int n = 0; n < 8; n++) chk(32'(hi[n]), exph(du[n], p, w, pol[n]));
    end
    for (int n = 0; n < 8; n++) du[n] = (n == 1) ? p + 1 : n * p / 8;
    cfg(8'hFF, 8'h00);
    for (int n = 0; n < 8; n++) chk(32'(hi[n]), expc(du[n], p, w, pol[n]));
    for (int n = 0; n < 8; n++) du[n] = n * p / 8;
    cfg(8'h00, 8'hFF);
    chk(32'(hi[0]), exph(0, p, w, pol[0]));
    for (int n = 1; n < 8; n++) chk(32'(hi[n]), exph(du[n], p, w, pol[n]));
    wr(`PWT_OFF_PCM, 32'h00, 2'h0);
    for (int n = 0; n < 8; n++) begin
      wr(`PWT_OFF_PERIOD0 + 8'(4 * n), n[0] ? 32'h01 : 32'h00, 2'h0);
      wr(`PWT_OFF_DUTY0 + 8'(4 * n), n[0] ? 32'h00 : 32'h80, 2'h0);
    end
    wr(`PWT_OFF_JOIN, 32'hF, 2'h0);
    meas(514);
    for (int n = 0; n < 8; n++) chk(32'(hi[n]), exph(128, 256, 514, pol[n]));
    rd(`PWT_OFF_JOIN, 32'hF, 2'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
